/* File: core/mixer_regs_pkg.sv */
// constants and types shared by the mixer control and power register bank
package mixer_regs_pkg;

	// ==================================================================
	// register offsets (byte index on the serial link)
	localparam logic [6:0] OFS_INPUT_GAIN_FIRST = 7'h0C;
	localparam logic [6:0] OFS_MIC_INPUT_GAIN = 7'h0E;
	localparam logic [6:0] OFS_INPUT_GAIN_LAST = 7'h18;
	localparam logic [6:0] OFS_RECORD_SOURCE_SELECT = 7'h1A;
	localparam logic [6:0] OFS_RECORD_GAIN_STEREO = 7'h1C;
	localparam logic [6:0] OFS_RECORD_GAIN_MIC_CHANNEL = 7'h1E;
	localparam logic [6:0] OFS_GENERAL_PURPOSE_CONTROL = 7'h20;
	localparam logic [6:0] OFS_SPATIAL_ENHANCE_CONTROL = 7'h22;
	localparam logic [6:0] OFS_MODEM_SAMPLE_RATE = 7'h24;
	localparam logic [6:0] OFS_POWERDOWN_CTRL_STATUS = 7'h26;
	localparam logic [6:0] OFS_RESERVED_RANGE = 7'h28;
	localparam logic [6:0] OFS_VENDOR_RESERVED_RANGE = 7'h5A;
	localparam logic [6:0] OFS_VENDOR_IDENT_FIRST = 7'h7C;
	localparam logic [6:0] OFS_VENDOR_IDENT_SECOND = 7'h7E;

	// ==================================================================
	// input gain bank: phone and mic are mono, the rest stereo
	localparam int NUM_INPUT_GAIN = 7;
	localparam int IDX_PHONE_GAIN = 0;
	localparam int IDX_MIC_GAIN = 1;

	// ==================================================================
	// reset values
	localparam logic [15:0] RST_MONO_GAIN = 16'h8008;
	localparam logic [15:0] RST_STEREO_GAIN = 16'h8808;
	localparam logic [15:0] RST_RECORD_SELECT = 16'h0000;
	localparam logic [15:0] RST_RECORD_GAIN = 16'h8000;
	localparam logic [15:0] RST_GENERAL = 16'h0000;
	localparam logic [15:0] RST_SPATIAL = 16'h0000;
	localparam logic [15:0] RST_MODEM_RATE = 16'h0000;
	localparam logic [7:0] RST_POWER_CTRL = 8'h00;

	// ==================================================================
	// implemented bits; the rest are stored as zero
	localparam logic [15:0] MASK_MONO_GAIN = 16'h801F;
	localparam logic [15:0] MASK_MIC_GAIN = 16'h805F;
	localparam logic [15:0] MASK_STEREO_GAIN = 16'h9F1F;
	localparam logic [15:0] MASK_RECORD_SELECT = 16'h0707;
	localparam logic [15:0] MASK_RECORD_GAIN = 16'h8F0F;
	localparam logic [15:0] MASK_RECORD_GAIN_MIC = 16'h800F;
	localparam logic [15:0] MASK_GENERAL = 16'hFF80;
	localparam logic [15:0] MASK_SPATIAL = 16'h0F0F;

	// highest legal modem rate, 48000 Hz
	localparam logic [15:0] MODEM_RATE_MAX = 16'hBB80;

	// ==================================================================
	// field positions
	localparam int BIT_MUTE = 15;
	localparam int BIT_MIC_BOOST = 6;
	localparam int BIT_PCM_PATH_AFTER_ENHANCE = 15;
	localparam int BIT_MONO_TO_WIDE_ON = 14;
	localparam int BIT_ENHANCE_3D_ON = 13;
	localparam int BIT_LOUDNESS_ON = 12;
	localparam int BIT_MODEM_LOCAL_LOOP = 11;
	localparam int BIT_MODEM_REMOTE_LOOP = 10;
	localparam int BIT_MONO_OUT_SOURCE = 9;
	localparam int BIT_MIC_SOURCE_SELECT = 8;
	localparam int BIT_CONVERTER_LOOPBACK = 7;
	localparam int PD_RECORD_PATH_OFF = 0;
	localparam int PD_LINK_OFF = 4;
	localparam int PD_MODEM_CONVERTERS_OFF = 7;

	// ==================================================================
	// identification; values are arbitrary
	localparam logic [7:0] VENDOR_CHAR_FIRST = 8'h51;
	localparam logic [7:0] VENDOR_CHAR_SECOND = 8'h52;
	localparam logic [7:0] VENDOR_CHAR_THIRD = 8'h53;
	localparam logic [7:0] VENDOR_ITERATION = 8'h01;

	// ==================================================================
	// types
	typedef logic [15:0] reg_word_t;

	typedef struct packed {
		logic valid;
		logic read;
		logic [6:0] addr;
		reg_word_t data;
	} reg_cmd_s;

	typedef struct packed {
		logic modem_ready;
		logic bias_level_ready;
		logic mixer_ready;
		logic playback_dac_ready;
		logic record_adc_ready;
	} ready_s;

	typedef struct packed {
		reg_word_t [NUM_INPUT_GAIN-1:0] input_gain;
		reg_word_t record_select;
		reg_word_t record_gain;
		reg_word_t record_gain_mic;
		reg_word_t general;
		reg_word_t spatial;
		reg_word_t modem_rate;
	} mixer_settings_s;

endpackage

/* File: core/mixer_control_power_regs.sv */
// mixer control, powerdown and identification register bank
`timescale 1ns/1ps

module mixer_control_power_regs
	import mixer_regs_pkg::*;
(
	// clock and cold reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST_B,
	// serial link pins
	input wire logic I_BIT_CLK,
	input wire logic I_SYNC,
	// register commands from the slot decoder
	input wire reg_cmd_s I_CMD,
	// readiness from the analog sections
	input wire ready_s I_READY,
	// register read answer and link status
	output logic O_RD_VALID,
	output reg_word_t O_RD_DATA,
	output logic O_CODEC_READY,
	output logic O_LINK_RUN,
	// settings to the mixer and converters
	output mixer_settings_s O_MIXER,
	output logic [7:0] O_POWER_OFF
);

	// ==================================================================
	// link state
	typedef enum logic [2:0] {
		ST_WAKING = 3'b001,
		ST_UP = 3'b010,
		ST_SLEEP = 3'b100
	} link_state_e;

	// ==================================================================
	// helpers
	function automatic logic hit(input logic [6:0] addr,
		input logic [6:0] ofs);
		hit = (addr == ofs);
	endfunction

	function automatic reg_word_t gain_mask(input int idx);
		if (idx == IDX_MIC_GAIN)
			gain_mask = MASK_MIC_GAIN;
		else if (idx == IDX_PHONE_GAIN)
			gain_mask = MASK_MONO_GAIN;
		else
			gain_mask = MASK_STEREO_GAIN;
	endfunction

	function automatic reg_word_t gain_reset(input int idx);
		if (idx == IDX_MIC_GAIN || idx == IDX_PHONE_GAIN)
			gain_reset = RST_MONO_GAIN;
		else
			gain_reset = RST_STEREO_GAIN;
	endfunction

	// ==================================================================
	// pin synchronisers
	logic bit_clk_meta_q;
	logic bit_clk_sync_q;
	logic bit_clk_last_q;
	logic sync_meta_q;
	logic sync_sync_q;
	logic sync_last_q;
	ready_s ready_meta_q;
	ready_s ready_sync_q;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			bit_clk_meta_q <= 1'b0;
			bit_clk_sync_q <= 1'b0;
			bit_clk_last_q <= 1'b0;
			sync_meta_q <= 1'b0;
			sync_sync_q <= 1'b0;
			sync_last_q <= 1'b0;
			ready_meta_q <= '0;
			ready_sync_q <= '0;
		end
		else
		begin
			bit_clk_meta_q <= I_BIT_CLK;
			bit_clk_sync_q <= bit_clk_meta_q;
			bit_clk_last_q <= bit_clk_sync_q;
			sync_meta_q <= I_SYNC;
			sync_sync_q <= sync_meta_q;
			sync_last_q <= sync_sync_q;
			ready_meta_q <= I_READY;
			ready_sync_q <= ready_meta_q;
		end
	end

	wire logic bit_clk_rise = bit_clk_sync_q & ~bit_clk_last_q;
	wire logic sync_rise = sync_sync_q & ~sync_last_q;

	// ==================================================================
	// command decode
	link_state_e state_q;
	link_state_e state_d;
	wire mixer_settings_s mixer_q;
	// one variable per register so that each has a single writer
	reg_word_t gain_q [NUM_INPUT_GAIN];
	wire reg_word_t [NUM_INPUT_GAIN-1:0] gain_w;
	reg_word_t record_select_q;
	reg_word_t record_gain_q;
	reg_word_t record_gain_mic_q;
	reg_word_t general_q;
	reg_word_t spatial_q;
	reg_word_t modem_rate_q;
	logic [7:0] power_q;

	wire logic cmd_take = I_CMD.valid & (state_q == ST_UP);
	wire logic wr_take = cmd_take & ~I_CMD.read;
	wire logic rd_take = cmd_take & I_CMD.read;
	wire reg_word_t wdata = I_CMD.data;
	wire logic [6:0] gain_off = I_CMD.addr - OFS_INPUT_GAIN_FIRST;
	wire logic gain_range = (I_CMD.addr >= OFS_INPUT_GAIN_FIRST) &
		(I_CMD.addr <= OFS_INPUT_GAIN_LAST) & ~gain_off[0];
	wire logic [2:0] gain_idx = gain_off[3:1];
	wire logic wr_power = wr_take & hit(I_CMD.addr, OFS_POWERDOWN_CTRL_STATUS);
	wire logic link_off_wr = wr_power & wdata[8 + PD_LINK_OFF];
	wire logic warm_wake = (state_q == ST_SLEEP) & sync_rise;

	// rates above the maximum are clamped on write
	wire reg_word_t rate_clamped = (wdata > MODEM_RATE_MAX) ?
		MODEM_RATE_MAX : wdata;

	// ==================================================================
	// input gain bank
	genvar g;
	generate
		for (g = 0; g < NUM_INPUT_GAIN; g++)
		begin : gen_gain
			wire logic wr_gain = wr_take & gain_range &
				(gain_idx == 3'(g));
			always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
			begin
				if (!I_RST_B)
					gain_q[g] <= gain_reset(g);
				else if (wr_gain)
					gain_q[g] <= wdata & gain_mask(g);
			end
			assign gain_w[g] = gain_q[g];
		end
	endgenerate

	assign mixer_q = {gain_w, record_select_q, record_gain_q,
		record_gain_mic_q, general_q, spatial_q, modem_rate_q};

	// ==================================================================
	// record, general, 3D and modem registers
	always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			record_select_q <= RST_RECORD_SELECT;
			record_gain_q <= RST_RECORD_GAIN;
			record_gain_mic_q <= RST_RECORD_GAIN;
			general_q <= RST_GENERAL;
			spatial_q <= RST_SPATIAL;
			modem_rate_q <= RST_MODEM_RATE;
		end
		else if (wr_take)
		begin
			if (hit(I_CMD.addr, OFS_RECORD_SOURCE_SELECT))
				record_select_q <= wdata & MASK_RECORD_SELECT;
			if (hit(I_CMD.addr, OFS_RECORD_GAIN_STEREO))
				record_gain_q <= wdata & MASK_RECORD_GAIN;
			if (hit(I_CMD.addr, OFS_RECORD_GAIN_MIC_CHANNEL))
				record_gain_mic_q <= wdata & MASK_RECORD_GAIN_MIC;
			if (hit(I_CMD.addr, OFS_GENERAL_PURPOSE_CONTROL))
				general_q <= wdata & MASK_GENERAL;
			if (hit(I_CMD.addr, OFS_SPATIAL_ENHANCE_CONTROL))
				spatial_q <= wdata & MASK_SPATIAL;
			if (hit(I_CMD.addr, OFS_MODEM_SAMPLE_RATE))
				modem_rate_q <= rate_clamped;
		end
	end

	// ==================================================================
	// powerdown control: high byte only; low byte is live status
	always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			power_q <= RST_POWER_CTRL;
		else if (warm_wake)
			power_q[PD_LINK_OFF] <= 1'b0;
		else if (wr_power)
			power_q <= wdata[15:8];
	end

	// ==================================================================
	// link state: wake waits for a bit clock edge before ready
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_WAKING:
				if (bit_clk_rise)
					state_d = ST_UP;
			ST_UP:
				if (link_off_wr)
					state_d = ST_SLEEP;
			ST_SLEEP:
				if (warm_wake)
					state_d = ST_WAKING;
			default:
				state_d = ST_WAKING;
		endcase
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
			state_q <= ST_WAKING;
		else
			state_q <= state_d;
	end

	// ==================================================================
	// read selection
	wire reg_word_t power_word = {power_q, 3'b000, ready_sync_q};
	wire reg_word_t ident_first = {VENDOR_CHAR_FIRST, VENDOR_CHAR_SECOND};
	wire reg_word_t ident_second = {VENDOR_CHAR_THIRD, VENDOR_ITERATION};
	wire reg_word_t gain_word = (gain_idx < 3'(NUM_INPUT_GAIN)) ?
		mixer_q.input_gain[gain_idx] : '0;

	// unimplemented and reserved locations read zero
	wire reg_word_t rd_word =
		gain_range ? gain_word :
		hit(I_CMD.addr, OFS_RECORD_SOURCE_SELECT) ? mixer_q.record_select :
		hit(I_CMD.addr, OFS_RECORD_GAIN_STEREO) ? mixer_q.record_gain :
		hit(I_CMD.addr, OFS_RECORD_GAIN_MIC_CHANNEL) ?
			mixer_q.record_gain_mic :
		hit(I_CMD.addr, OFS_GENERAL_PURPOSE_CONTROL) ? mixer_q.general :
		hit(I_CMD.addr, OFS_SPATIAL_ENHANCE_CONTROL) ? mixer_q.spatial :
		hit(I_CMD.addr, OFS_MODEM_SAMPLE_RATE) ? mixer_q.modem_rate :
		hit(I_CMD.addr, OFS_POWERDOWN_CTRL_STATUS) ? power_word :
		hit(I_CMD.addr, OFS_VENDOR_IDENT_FIRST) ? ident_first :
		hit(I_CMD.addr, OFS_VENDOR_IDENT_SECOND) ? ident_second :
		'0;

	// ==================================================================
	// registered outputs
	logic rd_valid_q;
	reg_word_t rd_data_q;
	logic codec_ready_q;
	logic link_run_q;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
	begin
		if (!I_RST_B)
		begin
			rd_valid_q <= 1'b0;
			rd_data_q <= '0;
			codec_ready_q <= 1'b0;
			link_run_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= rd_take;
			if (rd_take)
				rd_data_q <= rd_word;
			codec_ready_q <= (state_d == ST_UP);
			link_run_q <= (state_d != ST_SLEEP);
		end
	end

	// settings are held in flops that keep their value while idle
	assign O_RD_VALID = rd_valid_q;
	assign O_RD_DATA = rd_data_q;
	assign O_CODEC_READY = codec_ready_q;
	assign O_LINK_RUN = link_run_q;
	assign O_MIXER = mixer_q;
	assign O_POWER_OFF = power_q;

endmodule

/* File: bench/mixer_regs_chk.sv */
// port assertions for the mixer control and power register bank
`timescale 1ns/1ps
module mixer_regs_chk
	import mixer_regs_pkg::*;
(
	// clock, reset and inputs
	input wire logic I_SYS_CLK,
	input wire logic I_RST_B,
	input wire logic I_BIT_CLK,
	input wire reg_cmd_s I_CMD,
	// outputs
	input wire logic O_RD_VALID,
	input wire reg_word_t O_RD_DATA,
	input wire logic O_CODEC_READY,
	input wire logic O_LINK_RUN,
	input wire mixer_settings_s O_MIXER,
	input wire logic [7:0] O_POWER_OFF
);
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RST_B);
	// ==========================================================
	// commands that the bank takes
	wire tk = I_CMD.valid && O_CODEC_READY;
	wire rd = tk && I_CMD.read;
	wire wr = tk && !I_CMD.read;
	wire [6:0] a = I_CMD.addr;
	wire [15:0] d = I_CMD.data;
	// ==========================================================
	// assertions
	property p_rd; rd |=> O_RD_VALID; endproperty
	a_rd: assert property (p_rd) else $error("read unanswered");
	property p_nrd; !rd |=> !O_RD_VALID; endproperty
	a_nrd: assert property (p_nrd) else $error("stray answer");
	property p_vid; rd && a == OFS_VENDOR_IDENT_FIRST |=>
		O_RD_DATA == {VENDOR_CHAR_FIRST, VENDOR_CHAR_SECOND}; endproperty
	a_vid: assert property (p_vid) else $error("vendor_ident_first");
	property p_pdr; rd && a == OFS_POWERDOWN_CTRL_STATUS |=>
		O_RD_DATA[15:5] == {$past(O_POWER_OFF), 3'b000}; endproperty
	a_pdr: assert property (p_pdr) else $error("powerdown read");
	property p_pdw; wr && a == OFS_POWERDOWN_CTRL_STATUS |=>
		O_POWER_OFF == $past(d[15:8]); endproperty
	a_pdw: assert property (p_pdw) else $error("powerdown write");
	property p_slp; wr && a == OFS_POWERDOWN_CTRL_STATUS && d[12] |=>
		!O_CODEC_READY && !O_LINK_RUN; endproperty
	a_slp: assert property (p_slp) else $error("no sleep");
	property p_sel; wr && a == OFS_RECORD_SOURCE_SELECT |=>
		O_MIXER.record_select == ($past(d) & 16'h0707); endproperty
	a_sel: assert property (p_sel) else $error("record select");
	property p_rate; wr && a == OFS_MODEM_SAMPLE_RATE |=> O_MIXER.modem_rate
		== ($past(d) > 16'hBB80 ? 16'hBB80 : $past(d)); endproperty
	a_rate: assert property (p_rate) else $error("modem rate");
	property p_hold; !O_CODEC_READY |=> $stable(O_MIXER); endproperty
	a_hold: assert property (p_hold) else $error("lost setting");
	property p_up; O_LINK_RUN && !O_CODEC_READY && $rose(I_BIT_CLK)
		|-> ##[1:6] O_CODEC_READY; endproperty
	a_up: assert property (p_up) else $error("ready late");
	property p_wk; $rose(O_LINK_RUN) |-> !O_POWER_OFF[4]; endproperty
	a_wk: assert property (p_wk) else $error("link_off kept");
	c_rd: cover property (rd);
	c_slp: cover property (O_CODEC_READY ##1 !O_CODEC_READY);
	c_wk: cover property ($rose(O_LINK_RUN));
endmodule
bind mixer_control_power_regs mixer_regs_chk chk (.I_SYS_CLK(I_SYS_CLK),
	.I_RST_B(I_RST_B), .I_BIT_CLK(I_BIT_CLK), .I_CMD(I_CMD),
	.O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA),
	.O_CODEC_READY(O_CODEC_READY), .O_LINK_RUN(O_LINK_RUN),
	.O_MIXER(O_MIXER), .O_POWER_OFF(O_POWER_OFF));

/* File: bench/link_ctrl_model.sv */
// behavioural link controller: bit clock and warm wake pulse
`timescale 1ns/1ps
module link_ctrl_model (
	// control from the bench
	input wire logic i_run,
	input wire logic i_wake,
	// link pins toward the codec
	output logic o_bit_clk,
	output logic o_sync
);
	initial
	begin
		o_bit_clk = 1'b0;
		o_sync = 1'b0;
		#1;
		// clock stands still low while the link sleeps
		forever
			#62.5 o_bit_clk = i_run ? !o_bit_clk : 1'b0;
	end
	always @(posedge i_wake)
	begin
		o_sync = 1'b1;
		#1300 o_sync = 1'b0;
	end
endmodule

/* File: bench/mixer_control_power_regs_test.sv */
// self-checking bench for the mixer control and power register bank
`timescale 1ns/1ps
module mixer_control_power_regs_test
	import mixer_regs_pkg::*;
;
	logic clk = 0, rst_b = 0, run = 0, wake = 0;
	logic bclk, sync, rdv, cr, lr;
	reg_cmd_s cmd = '0;
	ready_s rdy = '0;
	reg_word_t rdd, q[$];
	reg_word_t rt [4] = '{16'hBB80, 16'hBB81, 16'hFFFF, 16'h1F40};
	mixer_settings_s mix;
	logic [7:0] pwr;
	int failures = 0, checks = 0;
	always #2.5 clk = ~clk;
	mixer_control_power_regs dut (.I_SYS_CLK(clk), .I_RST_B(rst_b),
		.I_BIT_CLK(bclk), .I_SYNC(sync), .I_CMD(cmd), .I_READY(rdy),
		.O_RD_VALID(rdv), .O_RD_DATA(rdd), .O_CODEC_READY(cr),
		.O_LINK_RUN(lr), .O_MIXER(mix), .O_POWER_OFF(pwr));
	link_ctrl_model far (.i_run(run), .i_wake(wake), .o_bit_clk(bclk),
		.o_sync(sync));
	// ==========================================================
	// checking and reporting
	task report_and_stop;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task fail(string m);
		failures++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task cmp_word(reg_word_t g, reg_word_t e);
		checks++;
		if (g !== e)
			fail($sformatf("read %h expected %h", g, e));
	endtask
	task cmp_bit(logic g, logic e);
		checks++;
		if (g !== e)
			fail("level wrong");
	endtask
	always @(negedge clk)
		if (rdv === 1'b1)
			if (q.size() == 0)
				fail("unexpected read answer");
			else
				cmp_word(rdd, q.pop_front());
	// ==========================================================
	// register port driving
	task cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task send(logic r, logic [6:0] a, reg_word_t d);
		cmd <= '{1'b1, r, a, d};
		cyc(1);
		cmd.valid <= 1'b0;
		cyc(1);
	endtask
	task wr(logic [6:0] a, reg_word_t d);
		send(1'b0, a, d);
	endtask
	task rd(logic [6:0] a, reg_word_t e);
		q.push_back(e);
		send(1'b1, a, 16'h0000);
	endtask
	task wait_ready;
		int i;
		for (i = 0; i < 400 && cr !== 1'b1; i++)
			cyc(1);
		if (cr !== 1'b1)
		begin
			fail("codec never ready");
			report_and_stop;
		end
	endtask
	function automatic reg_word_t msk(logic [6:0] a);
		case (a)
			7'h0C: return 16'h801F;
			7'h0E: return 16'h805F;
			7'h1A: return 16'h0707;
			7'h1C: return 16'h8F0F;
			7'h1E: return 16'h800F;
			7'h20: return 16'hFF80;
			7'h22: return 16'h0F0F;
			default: return 16'h9F1F;
		endcase
	endfunction
	function automatic reg_word_t dflt(logic [6:0] a);
		if (a < 7'h10)
			return 16'h8008;
		if (a < 7'h1A)
			return 16'h8808;
		if (a == 7'h1C || a == 7'h1E)
			return 16'h8000;
		return 16'h0000;
	endfunction
	task chk_defaults;
		logic [6:0] a;
		for (a = 7'h0C; a <= 7'h24; a += 2)
			rd(a, dflt(a));
		rd(7'h26, {8'h00, 3'b000, rdy});
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		reg_word_t d;
		reg_word_t gp;
		logic [6:0] a;
		int k;
		void'($urandom(32'h8b97_f4c5));
		rdy = ready_s'($urandom);
		cyc(16);
		rst_b <= 1'b1;
		run <= 1'b1;
		wait_ready;
		chk_defaults;
		rd(7'h7C, {VENDOR_CHAR_FIRST, VENDOR_CHAR_SECOND});
		rd(7'h7E, {VENDOR_CHAR_THIRD, VENDOR_ITERATION});
		$display("test defaults done");
		for (a = 7'h0C; a <= 7'h22; a += 2)
		begin
			d = 16'($urandom);
			wr(a, d);
			rd(a, d & msk(a));
			if (a == 7'h20)
				gp = d & msk(a);
		end
		for (k = 0; k < 4; k++)
		begin
			wr(7'h24, rt[k]);
			rd(7'h24, rt[k] > 16'hBB80 ? 16'hBB80 : rt[k]);
		end
		$display("test fields done");
		k = $urandom % 4;
		d = (16'($urandom) & 16'hE0FF) |
			((k == 3) ? 16'h0C00 : (16'h0100 << k));
		wr(7'h26, d);
		rdy <= ready_s'($urandom);
		cyc(4);
		rd(7'h26, {d[15:8], 3'b000, rdy});
		cmp_word({8'h00, pwr}, {8'h00, d[15:8]});
		wr(7'h5A, 16'($urandom));
		wr(7'h7C, 16'($urandom));
		rd(7'h28, 16'h0000);
		rd(7'h5A, 16'h0000);
		rd(7'h7C, {VENDOR_CHAR_FIRST, VENDOR_CHAR_SECOND});
		$display("test powerdown done");
		wr(7'h1A, 16'h0407);
		wr(7'h26, 16'h1200);
		cmp_bit(cr, 1'b0);
		cmp_bit(lr, 1'b0);
		run <= 1'b0;
		wr(7'h1A, 16'h0000);
		cyc(10);
		wake <= 1'b1;
		for (k = 0; k < 400 && lr !== 1'b1; k++)
			cyc(1);
		cmp_bit(lr, 1'b1);
		if (lr !== 1'b1)
			report_and_stop;
		cmp_bit(pwr[4], 1'b0);
		wake <= 1'b0;
		// bit clock restarts only after the sync pulse has ended
		cyc(300);
		run <= 1'b1;
		wait_ready;
		rd(7'h26, {8'h02, 3'b000, rdy});
		rd(7'h1A, 16'h0407);
		$display("test sleep done");
		rd(7'h20, gp);
		wr(7'h20, gp | 16'h0080);
		rd(7'h20, gp | 16'h0080);
		rst_b <= 1'b0;
		cyc(16);
		rst_b <= 1'b1;
		wait_ready;
		chk_defaults;
		$display("test cold reset done");
		cyc(4);
		if (q.size() != 0)
			fail("reads unanswered");
		report_and_stop;
	end
endmodule
